// ### bench/pmsw_checker.sv
// Checker for pmsw_ctrl: write slots, stall span, permissions.
// Assumes a bind to the controller's ports.
`timescale 1ns/100ps
`include "pmsw_map.svh"
module pmsw_checker (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_self_program_allow,
  input wire logic i_protect_code_hi,
  input wire logic i_protect_code_lo,
  input wire logic i_loc_protected,
  input wire logic i_prog_rd_req,
  input wire logic i_prog_wr_req,
  input wire logic [7:0] o_nvm_addr_low,
  input wire logic [7:0] o_nvm_control,
  input wire logic o_nvm_done_flag,
  input wire logic o_discard,
  input wire logic o_stall,
  input wire logic o_flash_write,
  input wire logic o_prog_rd_ok,
  input wire logic o_prog_wr_ok
);
  int unsigned stall_cnt_r;
  int unsigned stall_cnt_nxt;
  logic [1:0] code;
  assign code = {i_protect_code_hi, i_protect_code_lo};
  // Stall span counter, cleared whenever the stall drops
  always_comb stall_cnt_nxt = o_stall ? stall_cnt_r + 1 : 0;
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) stall_cnt_r <= 0;
    else stall_cnt_r <= stall_cnt_nxt;
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  a_go_needs_permit: assert property ($rose(o_nvm_control[1]) |-> $past(o_nvm_control[2]))
    else $error("go set without earlier permit");
  a_flash_after_slots: assert property (o_flash_write |-> o_stall && $past(o_discard) && !$past(o_stall))
    else $error("flash write not after the discard slot");
  a_flash_allowed: assert property (o_flash_write |-> i_self_program_allow && code != 2'b00 && (code == 2'b11 || !i_loc_protected))
    else $error("flash write while not permitted");
  a_stall_span: assert property ($fell(o_stall) |-> stall_cnt_r == `PMSW_PEW_CYCLES)
    else $error("stall span wrong");
  a_stall_end: assert property ($fell(o_stall) |-> ##[0:1] (o_nvm_done_flag && !o_nvm_control[1]))
    else $error("done or go wrong at end of stall");
  a_stall_holds: assert property (o_stall && $past(o_stall) |-> $stable(o_nvm_addr_low) && $stable(o_nvm_control[7]))
    else $error("staging changed during stall");
  a_prog_read: assert property (o_prog_rd_ok == $past(i_prog_rd_req && (code == 2'b11 || (code != 2'b00 && !i_loc_protected))))
    else $error("programmer read permission wrong");
  a_prog_write: assert property (o_prog_wr_ok == $past(i_prog_wr_req && code == 2'b11))
    else $error("programmer write permission wrong");
endmodule

// ### bench/tb.sv
// Testbench for pmsw_ctrl: staging, unlock keys, stall and permission matrix.
// Assumes inputs change 1 ns after the rising edge; short power-up count.
`timescale 1ns/100ps
module tb;
  logic i_mclk = 0, i_reset = 1, i_done_clear = 0, i_full_erase = 0, i_data_busy = 0;
  logic i_self_program_allow = 1, i_protect_code_hi = 1, i_protect_code_lo = 1, i_loc_protected = 0;
  logic i_prog_rd_req = 0, i_prog_wr_req = 0;
  logic [5:0] stb = 6'h00;
  logic [7:0] i_wdata = 8'h00, o_nvm_addr_low, o_nvm_addr_high, o_nvm_value_low, o_nvm_value_high, o_nvm_control;
  logic o_nvm_done_flag, o_discard, o_stall, o_flash_write, o_data_write, o_prog_rd_ok, o_prog_wr_ok;
  logic o_int_read_ok, o_cfg_erase;
  int n_fail = 0, n_compared = 0, n_fw = 0, n_dw = 0;
  pmsw_ctrl #(.PWRT_CYCLES(20)) uut (.*, .i_wr_addr_low(stb[0]), .i_wr_addr_high(stb[1]),
    .i_wr_value_low(stb[2]), .i_wr_value_high(stb[3]), .i_wr_control(stb[4]), .i_wr_key(stb[5]));
  always #5 i_mclk = ~i_mclk;
  // Pulse counters for the two write strobes
  always @(posedge i_mclk) begin
    n_fw += o_flash_write;
    n_dw += o_data_write;
  end
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One register write per instruction cycle
  task automatic wr(input int k, input logic [7:0] d);
    stb = 6'h01 << k;
    i_wdata = d;
    @(posedge i_mclk);
    #1;
  endtask
  task automatic idle(input int n);
    stb = 6'h00;
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  // Unlock and go, poke staging mid-stall, then wait and clear done
  task automatic attempt(input logic [3:0] cfg, input bit gap, input logic [7:0] pre, input logic [7:0] go);
    {i_self_program_allow, i_protect_code_hi, i_protect_code_lo, i_loc_protected} = cfg;
    wr(4, pre);
    wr(5, 8'h55);
    if (gap) idle(1);
    wr(5, 8'hAA);
    wr(4, go);
    idle(4); // No-op slots after go
    wr(0, 8'hFF);
    idle(0);
    for (int k = 0; k < 300 && o_nvm_done_flag !== 1'b1; k++) @(posedge i_mclk);
    #1 i_done_clear = 1;
    idle(1);
    i_done_clear = 0;
    idle(1);
    chk("done_flag", o_nvm_done_flag, 0);
  endtask
  task automatic test_done();
    if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard, well past the expected few thousand cycles
  initial begin
    #100us;
    n_fail++;
    test_done();
  end
  initial begin
    idle(2);
    i_reset = 0;
    chk("control", o_nvm_control, 8'h00);
    chk("int_read_ok", o_int_read_ok, 1);
    attempt(4'hE, 0, 8'h04, 8'h06);
    chk("early data writes", n_dw, 0);
    i_reset = 1;
    idle(2);
    i_reset = 0;
    idle(25);
    attempt(4'hE, 0, 8'h04, 8'h06);
    chk("data writes", n_dw, 1);
    for (int k = 0; k < 4; k++) wr(k, 8'h31 + k);
    attempt(4'hE, 0, 8'h84, 8'h86);
    chk("flash writes", n_fw, 1);
    chk("addr_low", o_nvm_addr_low, 8'h31);
    chk("value_high", o_nvm_value_high, 8'h34);
    chk("addr_high", o_nvm_addr_high, 8'h32);
    chk("value_low", o_nvm_value_low, 8'h33);
    chk("control", o_nvm_control, 8'h84);
    // Refused writes: late permit, key gap, no allow, protected, full protection
    attempt(4'hE, 0, 8'h80, 8'h86);
    attempt(4'hE, 1, 8'h84, 8'h86);
    attempt(4'h6, 0, 8'h84, 8'h86);
    attempt(4'hB, 0, 8'h84, 8'h86);
    attempt(4'h8, 0, 8'h84, 8'h86);
    chk("flash writes", n_fw, 1);
    // Code 11 leaves every location writable, protected or not
    attempt(4'hF, 0, 8'h84, 8'h86);
    chk("flash writes", n_fw, 2);
    i_prog_rd_req = 1;
    i_prog_wr_req = 1;
    for (int c = 0; c < 8; c++) begin
      {i_protect_code_hi, i_protect_code_lo, i_loc_protected} = c[2:0];
      idle(2);
      chk("prog_rd_ok", o_prog_rd_ok, c[2:1] == 3 || (c[2:1] != 0 && !c[0]));
      chk("prog_wr_ok", o_prog_wr_ok, c[2:1] == 3);
    end
    i_full_erase = 1;
    idle(2);
    chk("cfg_erase", o_cfg_erase, 1);
    test_done();
  end
endmodule
bind pmsw_ctrl pmsw_checker chk_i (.*);

// ### hdl/pmsw_ctrl.sv
// Program-memory self-write controller: staging registers, unlock keys,
// instruction stall and the code-protect permission matrix.
// Assumes the core presents one register write per instruction cycle on i_mclk.
`timescale 1ns/100ps
`include "pmsw_map.svh"

module pmsw_ctrl #(
  parameter int unsigned PWRT_CYCLES = `PMSW_PWRT_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_wr_addr_low,
  input wire logic i_wr_addr_high,
  input wire logic i_wr_value_low,
  input wire logic i_wr_value_high,
  input wire logic i_wr_control,
  input wire logic i_wr_key,
  input wire logic [7:0] i_wdata,
  input wire logic i_done_clear,
  input wire logic i_self_program_allow,
  input wire logic i_protect_code_hi,
  input wire logic i_protect_code_lo,
  input wire logic i_loc_protected,
  input wire logic i_full_erase,
  input wire logic i_prog_rd_req,
  input wire logic i_prog_wr_req,
  input wire logic i_data_busy,
  output logic [7:0] o_nvm_addr_low,
  output logic [7:0] o_nvm_addr_high,
  output logic [7:0] o_nvm_value_low,
  output logic [7:0] o_nvm_value_high,
  output logic [7:0] o_nvm_control,
  output logic o_nvm_done_flag,
  output logic o_discard,
  output logic o_stall,
  output logic o_flash_write,
  output logic o_data_write,
  output logic o_prog_rd_ok,
  output logic o_prog_wr_ok,
  output logic o_int_read_ok,
  output logic o_cfg_erase
);
  import pmsw_pkg::*;

  // Internal program write permission from the configuration matrix
  function automatic logic int_wr_ok(input logic allow, input logic [1:0] cp, input logic prot);
    int_wr_ok = allow && (cp != `PMSW_CP_ALL) && ((cp == `PMSW_CP_NONE) || !prot);
  endfunction

  pmsw_state_t state_r, state_nxt;
  pmsw_key_t key_r, key_nxt;
  logic [7:0] addr_lo_r, addr_lo_nxt, addr_hi_r, addr_hi_nxt;
  logic [7:0] val_lo_r, val_lo_nxt, val_hi_r, val_hi_nxt;
  logic space_r, space_nxt, permit_r, permit_nxt, go_r, go_nxt, err_r, err_nxt;
  logic done_r, done_nxt, disc_r, disc_nxt, stall_r, stall_nxt;
  logic fw_r, fw_nxt, dw_r, dw_nxt;
  logic prd_r, prd_nxt, pwr_r, pwr_nxt, erase_r, erase_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [31:0] pwrt_r, pwrt_nxt;
  logic [1:0] cp;
  logic go_req, start_ok;

  assign cp = {i_protect_code_hi, i_protect_code_lo};
  // Go is honoured only after both keys and an earlier permit
  assign go_req = i_wr_control && i_wdata[`PMSW_CTL_GO] && !go_r;
  assign start_ok = go_req && permit_r && (key_r == PMSW_KEY_GOTAA);

  // Next-state logic for the write sequencer and software-visible bits
  always_comb begin
    state_nxt = state_r;
    key_nxt = PMSW_KEY_NONE;
    addr_lo_nxt = addr_lo_r;
    addr_hi_nxt = addr_hi_r;
    val_lo_nxt = val_lo_r;
    val_hi_nxt = val_hi_r;
    space_nxt = space_r;
    permit_nxt = permit_r;
    go_nxt = go_r;
    err_nxt = err_r;
    done_nxt = done_r;
    disc_nxt = 1'b0;
    stall_nxt = 1'b0;
    fw_nxt = 1'b0;
    dw_nxt = 1'b0;
    cnt_nxt = cnt_r;
    pwrt_nxt = (pwrt_r != 32'h0000_0000) ? pwrt_r - 32'h0000_0001 : pwrt_r;
    // Keys must arrive on back-to-back cycles; anything else drops them
    if (i_wr_key && i_wdata == `PMSW_KEY_FIRST) begin
      key_nxt = PMSW_KEY_GOT55;
    end else if (i_wr_key && i_wdata == `PMSW_KEY_SECOND && key_r == PMSW_KEY_GOT55) begin
      key_nxt = PMSW_KEY_GOTAA;
    end
    // Staging writes frozen while a write is in flight
    if (!go_r) begin
      if (i_wr_addr_low) addr_lo_nxt = i_wdata;
      if (i_wr_addr_high) addr_hi_nxt = i_wdata;
      if (i_wr_value_low) val_lo_nxt = i_wdata;
      if (i_wr_value_high) val_hi_nxt = i_wdata;
    end
    if (i_wr_control) begin
      permit_nxt = i_wdata[`PMSW_CTL_PERMIT];
      err_nxt = i_wdata[`PMSW_CTL_ERR];
      if (!go_r && !i_data_busy) space_nxt = i_wdata[`PMSW_CTL_SPACE];
    end
    // Done flag: hardware set wins over software clear
    if (i_done_clear) done_nxt = 1'b0;
    case (state_r)
      PMSW_IDLE: begin
        if (start_ok) begin
          go_nxt = 1'b1;
          if (space_r) begin
            state_nxt = PMSW_SLOT_RUN;
          end else if (pwrt_r == 32'h0000_0000) begin
            dw_nxt = 1'b1; // Data write handed to the data array
          end else begin
            go_nxt = 1'b0;
          end
        end
        if (go_r && !space_r && !i_data_busy && !dw_r) begin
          go_nxt = 1'b0;
          done_nxt = 1'b1;
        end
      end
      PMSW_SLOT_RUN: begin
        disc_nxt = 1'b1; // Second slot after go is dropped
        state_nxt = PMSW_SLOT_DROP;
      end
      PMSW_SLOT_DROP: begin
        cnt_nxt = `PMSW_PEW_CYCLES;
        stall_nxt = 1'b1;
        state_nxt = PMSW_STALL;
        // Only a permitted location is really programmed
        fw_nxt = int_wr_ok(i_self_program_allow, cp, i_loc_protected);
      end
      PMSW_STALL: begin
        cnt_nxt = cnt_r - 32'h0000_0001;
        stall_nxt = 1'b1;
        if (cnt_r == 32'h0000_0001) begin
          stall_nxt = 1'b0; // Release lands on the third instruction
          go_nxt = 1'b0;
          done_nxt = 1'b1;
          state_nxt = PMSW_IDLE;
        end
      end
      default: state_nxt = PMSW_IDLE;
    endcase
  end

  // Serial programmer gating and config erase pass-through
  always_comb begin
    // Programmer writes need code 11; reads also pass for unprotected locations under codes 01 and 10
    prd_nxt = i_prog_rd_req && (cp != `PMSW_CP_ALL) && ((cp == `PMSW_CP_NONE) || !i_loc_protected);
    pwr_nxt = i_prog_wr_req && (cp == `PMSW_CP_NONE);
    erase_nxt = i_full_erase; // Config bits return to erased only here
  end

  // State registers; power-on reset clears the permit
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      state_r <= PMSW_IDLE;
      key_r <= PMSW_KEY_NONE;
      addr_lo_r <= 8'h00;
      addr_hi_r <= 8'h00;
      val_lo_r <= 8'h00;
      val_hi_r <= 8'h00;
      space_r <= 1'b0;
      permit_r <= 1'b0;
      go_r <= 1'b0;
      err_r <= 1'b0;
      done_r <= 1'b0;
      disc_r <= 1'b0;
      stall_r <= 1'b0;
      fw_r <= 1'b0;
      dw_r <= 1'b0;
      cnt_r <= 32'h0000_0000;
      pwrt_r <= PWRT_CYCLES; // Power-up timer starts at reset
      prd_r <= 1'b0;
      pwr_r <= 1'b0;
      erase_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      key_r <= key_nxt;
      addr_lo_r <= addr_lo_nxt;
      addr_hi_r <= addr_hi_nxt;
      val_lo_r <= val_lo_nxt;
      val_hi_r <= val_hi_nxt;
      space_r <= space_nxt;
      permit_r <= permit_nxt;
      go_r <= go_nxt;
      err_r <= err_nxt;
      done_r <= done_nxt;
      disc_r <= disc_nxt;
      stall_r <= stall_nxt;
      fw_r <= fw_nxt;
      dw_r <= dw_nxt;
      cnt_r <= cnt_nxt;
      pwrt_r <= pwrt_nxt;
      prd_r <= prd_nxt;
      pwr_r <= pwr_nxt;
      erase_r <= erase_nxt;
    end
  end

  // Outputs straight from flops, except o_int_read_ok tied high and the constant zero bits of o_nvm_control
  assign o_nvm_addr_low = addr_lo_r;
  assign o_nvm_addr_high = addr_hi_r;
  assign o_nvm_value_low = val_lo_r;
  assign o_nvm_value_high = val_hi_r;
  assign o_nvm_control = {space_r, 3'b000, err_r, permit_r, go_r, 1'b0};
  assign o_nvm_done_flag = done_r;
  assign o_discard = disc_r;
  assign o_stall = stall_r;
  assign o_flash_write = fw_r;
  assign o_data_write = dw_r;
  assign o_prog_rd_ok = prd_r;
  assign o_prog_wr_ok = pwr_r;
  assign o_int_read_ok = 1'b1; // Processor reads never gated
  assign o_cfg_erase = erase_r;
endmodule

// ### hdl/pmsw_map.svh
// Constants for the program-memory self-write controller.
// Assumes one instruction cycle per i_mclk edge at 100 MHz.
`ifndef PMSW_MAP_SVH
`define PMSW_MAP_SVH
`define PMSW_KEY_FIRST 8'h55
`define PMSW_KEY_SECOND 8'hAA
`define PMSW_CTL_SPACE 7
`define PMSW_CTL_ERR 3
`define PMSW_CTL_PERMIT 2
`define PMSW_CTL_GO 1
`define PMSW_CTL_RD 0
`define PMSW_CTL_RESET 8'h00
`define PMSW_CLK_NS 10
`define PMSW_PWRT_MS 72
`define PMSW_PWRT_CYCLES ((`PMSW_PWRT_MS * 1000000) / `PMSW_CLK_NS)
`define PMSW_PEW_US 2
`define PMSW_PEW_CYCLES (((`PMSW_PEW_US * 1000) + `PMSW_CLK_NS - 1) / `PMSW_CLK_NS)
`define PMSW_CP_NONE 2'b11
`define PMSW_CP_ALL 2'b00
`endif

// ### hdl/pmsw_pkg.sv
// Types for the program-memory self-write controller.
// Assumes pmsw_map.svh supplies the numeric constants.
package pmsw_pkg;
  typedef enum logic [2:0] {
    PMSW_IDLE,
    PMSW_SLOT_RUN,
    PMSW_SLOT_DROP,
    PMSW_STALL
  } pmsw_state_t;
  typedef enum logic [1:0] {
    PMSW_KEY_NONE,
    PMSW_KEY_GOT55,
    PMSW_KEY_GOTAA
  } pmsw_key_t;
endpackage
